// ==== design/tscw_top.sv ====
// Terminal status control word decoder for the operator terminal.
//
// Operation
// - Bit 14 set grants link processing priority.
// - Bit 14 cleared cancels priority registration.
// - Most recent registration among terminals wins.
// - Priority only in multi-drop link mode.
// - Bit 13 drives buzzer continuously.
// - Bit 12 gives 0.5 s on/off.
// - Bit 9 gives 1.0 s on/off.
// - Buzzer priority: continuous, short, long.
// - Buzzer-stop touch switch silences buzzer.
// - Buzzer configuration switch gates output.
// - Screen attribute may request a buzzer.
// - Bit 11 rising initialises display history.
// - History bit returns to zero afterwards.
// - Bit 7 rising starts unstoppable screen print.
// - Print bit cleared once busy is set.
// - Bit 6 blocks and closes windows.
// - Bit 5 blocks numeric and string entry.
// - Start-up content ignored; only changes act.
// - Bit 15 clear blanks; set/touch restores.
// - Printer busy high while printing.
// - Local changes never rewrite control bits.
`timescale 1ns/1ps
`default_nettype none
module tscw_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] ctrl_word_in,
  input wire logic ctrl_word_wr,
  input wire logic startup_done,
  input wire tscw_pkg::tscw_local_t local_in,
  output logic [15:0] ctrl_word_out,
  output logic ctrl_word_out_wr,
  output tscw_pkg::tscw_ctrl_t ctrl_out
);
  import tscw_pkg::*;

  // Whole state of the top level.
  typedef struct packed {
    logic [15:0] word;
    logic running;
    logic display;
    logic priority_reg;
    logic win_inh;
    logic ent_inh;
    logic buz_silenced;
    logic scr_silenced;
    logic hist_pend;
    tscw_pr_t pr;
    tscw_ctrl_t out;
    logic [15:0] wb;
    logic wb_wr;
  } tscw_st_t;

  tscw_st_t st;
  tscw_st_t next_st;
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] held;
  logic [15:0] view;
  tscw_buz_t host_sel;
  tscw_buz_t sel;
  logic tone;

  // The word seen by the detector follows host writes once running.
  assign view = (ctrl_word_wr && st.running) ? ctrl_word_in : held;

  // Change detector, armed only after start-up completes.
  tscw_edge u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .arm(st.running),
    .word(view),
    .rise(rise),
    .fall(fall),
    .held(held)
  );

  // Host buzzer request by fixed priority.
  always_comb begin
    host_sel = TSCW_BUZ_OFF;
    if (held[BIT_BUZ_CONT]) begin
      host_sel = TSCW_BUZ_CONT;
    end else if (held[BIT_BUZ_SHORT]) begin
      host_sel = TSCW_BUZ_SHORT;
    end else if (held[BIT_BUZ_LONG]) begin
      host_sel = TSCW_BUZ_LONG;
    end
  end

  // Final pattern: host request, else the screen attribute request.
  always_comb begin
    sel = TSCW_BUZ_OFF;
    if (host_sel != TSCW_BUZ_OFF && !st.buz_silenced) begin
      sel = host_sel;
    end else if (local_in.screen_buz_req && !st.scr_silenced) begin
      sel = local_in.screen_buz_kind;
    end
    if (!local_in.buzzer_enable_sw) begin
      sel = TSCW_BUZ_OFF;
    end
  end

  // Pattern generator.
  tscw_buzz u_buzz (
    .clk(clk),
    .rst_n(rst_n),
    .sel(sel),
    .tone(tone)
  );

  // Next-state logic for all control effects.
  always_comb begin
    next_st = st;
    next_st.wb_wr = 1'b0;
    next_st.out.hist_init = 1'b0;
    next_st.out.print_start = 1'b0;
    next_st.out.window_close = 1'b0;
    if (startup_done) begin
      next_st.running = 1'b1;
    end

    // Screen display: clear blanks, set or touch restores.
    if (fall[BIT_DISPLAY]) begin
      next_st.display = 1'b0;
    end else if (rise[BIT_DISPLAY] || local_in.touch_any) begin
      next_st.display = 1'b1;
    end

    // Priority registration follows bit 14 transitions.
    if (rise[BIT_PRIORITY]) begin
      next_st.priority_reg = 1'b1;
    end else if (fall[BIT_PRIORITY]) begin
      next_st.priority_reg = 1'b0;
    end

    // Buzzer silence: a stop switch mutes the host request until a bit rises again, the screen request until it drops.
    if (rise[BIT_BUZ_CONT] || rise[BIT_BUZ_SHORT] || rise[BIT_BUZ_LONG]) begin
      next_st.buz_silenced = 1'b0;
    end else if (local_in.touch_buz_stop) begin
      next_st.buz_silenced = 1'b1;
    end
    if (!local_in.screen_buz_req) begin
      next_st.scr_silenced = 1'b0;
    end else if (local_in.touch_buz_stop) begin
      next_st.scr_silenced = 1'b1;
    end

    // Window and entry inhibits act on changes only.
    if (rise[BIT_WIN_INHIBIT]) begin
      next_st.win_inh = 1'b1;
      next_st.out.window_close = 1'b1;
    end else if (fall[BIT_WIN_INHIBIT]) begin
      next_st.win_inh = 1'b0;
    end
    if (rise[BIT_ENTRY_INHIBIT]) begin
      next_st.ent_inh = 1'b1;
    end else if (fall[BIT_ENTRY_INHIBIT]) begin
      next_st.ent_inh = 1'b0;
    end

    // Display history: pulse on rise, clear bit on completion.
    if (rise[BIT_HIST_RESET]) begin
      next_st.out.hist_init = 1'b1;
      next_st.hist_pend = 1'b1;
    end else if (st.hist_pend && local_in.hist_done) begin
      next_st.hist_pend = 1'b0;
      next_st.wb = held & ~(16'h0001 << BIT_HIST_RESET);
      next_st.wb_wr = 1'b1;
    end

    // Print handshake: start, go busy, clear bit, wait for done.
    case (st.pr)
      TSCW_PR_IDLE: begin
        if (rise[BIT_PRINT]) begin
          next_st.out.print_start = 1'b1;
          next_st.pr = TSCW_PR_START;
        end
      end
      TSCW_PR_START: begin
        next_st.out.printer_busy = 1'b1;
        next_st.wb = held & ~(16'h0001 << BIT_PRINT);
        next_st.wb_wr = 1'b1;
        next_st.pr = TSCW_PR_BUSY;
      end
      TSCW_PR_BUSY: begin
        if (local_in.print_done) begin
          next_st.out.printer_busy = 1'b0;
          next_st.pr = TSCW_PR_IDLE;
        end
      end
      default: begin
        next_st.pr = TSCW_PR_IDLE;
      end
    endcase

    // Registered outputs; local state changes never touch the word.
    next_st.word = held;
    next_st.out.display_on = next_st.display;
    next_st.out.backlight_on = next_st.display;
    next_st.out.priority_req = next_st.priority_reg
      & local_in.multi_drop_mode;
    next_st.out.window_inhibit = next_st.win_inh;
    next_st.out.entry_inhibit = next_st.ent_inh;
    next_st.out.buzzer = tone;
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{word: CTRL_RESET, running: 1'b0, display: 1'b1,
              priority_reg: 1'b0, win_inh: 1'b0, ent_inh: 1'b0,
              buz_silenced: 1'b0, scr_silenced: 1'b0, hist_pend: 1'b0,
              pr: TSCW_PR_IDLE,
              out: '{display_on: 1'b1, backlight_on: 1'b1,
                     default: 1'b0},
              wb: CTRL_RESET, wb_wr: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops.
  assign ctrl_word_out = st.wb;
  assign ctrl_word_out_wr = st.wb_wr;
  assign ctrl_out = st.out;
endmodule
`default_nettype wire

// ==== design/tscw_pkg.sv ====
// Package with constants and types for the terminal status control word.
package tscw_pkg;

  // Bit positions inside the 16-bit control word.
  localparam int unsigned BIT_DISPLAY = 15;
  localparam int unsigned BIT_PRIORITY = 14;
  localparam int unsigned BIT_BUZ_CONT = 13;
  localparam int unsigned BIT_BUZ_SHORT = 12;
  localparam int unsigned BIT_HIST_RESET = 11;
  localparam int unsigned BIT_BUZ_LONG = 9;
  localparam int unsigned BIT_PRINT = 7;
  localparam int unsigned BIT_WIN_INHIBIT = 6;
  localparam int unsigned BIT_ENTRY_INHIBIT = 5;

  // Reset value of the held control word copy.
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Clock rate and buzzer phase times.
  localparam longint unsigned CLK_HZ = 64'd50000000;
  localparam longint unsigned SHORT_PHASE_MS = 64'd500;
  localparam longint unsigned LONG_PHASE_MS = 64'd1000;
  localparam longint unsigned SHORT_PHASE_CYC = CLK_HZ * SHORT_PHASE_MS / 1000;
  localparam longint unsigned LONG_PHASE_CYC = CLK_HZ * LONG_PHASE_MS / 1000;
  localparam int unsigned TMR_W = 26;

  // Buzzer pattern selection, one-hot.
  typedef enum logic [3:0] {
    TSCW_BUZ_OFF = 4'h1,
    TSCW_BUZ_CONT = 4'h2,
    TSCW_BUZ_SHORT = 4'h4,
    TSCW_BUZ_LONG = 4'h8
  } tscw_buz_t;

  // Print handshake states, one-hot.
  typedef enum logic [2:0] {
    TSCW_PR_IDLE = 3'h1,
    TSCW_PR_START = 3'h2,
    TSCW_PR_BUSY = 3'h4
  } tscw_pr_t;

  // Local events from the terminal side.
  typedef struct packed {
    logic touch_any;
    logic touch_buz_stop;
    logic screen_buz_req;
    tscw_buz_t screen_buz_kind;
    logic buzzer_enable_sw;
    logic multi_drop_mode;
    logic print_done;
    logic hist_done;
  } tscw_local_t;

  // Control outputs to the terminal.
  typedef struct packed {
    logic display_on;
    logic backlight_on;
    logic priority_req;
    logic buzzer;
    logic hist_init;
    logic print_start;
    logic printer_busy;
    logic window_inhibit;
    logic window_close;
    logic entry_inhibit;
  } tscw_ctrl_t;

endpackage

// ==== design/tscw_edge.sv ====
// Change detector over the control word: compares new word to held copy.
`timescale 1ns/1ps
`default_nettype none
module tscw_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic arm,
  input wire logic [15:0] word,
  output logic [15:0] rise,
  output logic [15:0] fall,
  output logic [15:0] held
);
  import tscw_pkg::*;

  // Whole state of the detector.
  typedef struct packed {
    logic [15:0] held;
    logic armed;
  } tscw_edge_st_t;

  tscw_edge_st_t st;
  tscw_edge_st_t next_st;

  // Edges only count once armed, so the start-up content is ignored.
  always_comb begin
    next_st = st;
    next_st.held = word;
    if (arm) begin
      next_st.armed = 1'b1;
    end
  end

  // Per-bit transitions versus the held copy.
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_bit
      assign rise[i] = st.armed & word[i] & ~st.held[i];
      assign fall[i] = st.armed & ~word[i] & st.held[i];
    end
  endgenerate
  assign held = st.held;

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{held: CTRL_RESET, armed: 1'b0};
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ==== design/tscw_buzz.sv ====
// Buzzer pattern generator: steady, 0.5 s or 1.0 s on/off patterns.
`timescale 1ns/1ps
`default_nettype none
module tscw_buzz (
  input wire logic clk,
  input wire logic rst_n,
  input wire tscw_pkg::tscw_buz_t sel,
  output logic tone
);
  import tscw_pkg::*;

  // Whole state of the generator.
  typedef struct packed {
    tscw_buz_t last;
    logic [TMR_W-1:0] cnt;
    logic phase_on;
  } tscw_bz_st_t;

  tscw_bz_st_t st;
  tscw_bz_st_t next_st;
  logic [TMR_W-1:0] limit;

  // Phase length for the chosen pattern.
  always_comb begin
    limit = TMR_W'(SHORT_PHASE_CYC - 1);
    if (sel == TSCW_BUZ_LONG) begin
      limit = TMR_W'(LONG_PHASE_CYC - 1);
    end
  end

  // Counter restarts in the on phase whenever the pattern changes.
  always_comb begin
    next_st = st;
    next_st.last = sel;
    if (sel != st.last) begin
      next_st.cnt = '0;
      next_st.phase_on = 1'b1;
    end else if (st.cnt >= limit) begin
      next_st.cnt = '0;
      next_st.phase_on = ~st.phase_on;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  // Tone is steady for continuous, phased for intermittent.
  always_comb begin
    case (sel)
      TSCW_BUZ_CONT: tone = 1'b1;
      TSCW_BUZ_SHORT: tone = (sel == st.last) & st.phase_on;
      TSCW_BUZ_LONG: tone = (sel == st.last) & st.phase_on;
      default: tone = 1'b0;
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{last: TSCW_BUZ_OFF, cnt: '0, phase_on: 1'b1};
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ==== verif/tscw_chk.sv ====
// Port checker for the control word decoder.
`timescale 1ns/1ps
`default_nettype none
module tscw_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire tscw_pkg::tscw_local_t local_in,
  input wire logic [15:0] ctrl_word_out,
  input wire logic ctrl_word_out_wr,
  input wire tscw_pkg::tscw_ctrl_t ctrl_out
);
  import tscw_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A print start is followed by busy one cycle later.
  sequence print_go;
    ctrl_out.print_start ##1 ctrl_out.printer_busy;
  endsequence
  prio_mode_a: assert property (
    !local_in.multi_drop_mode [*2] |-> !ctrl_out.priority_req)
    else $error("priority outside multi-drop");
  buz_gate_a: assert property (
    !local_in.buzzer_enable_sw [*2] |-> !ctrl_out.buzzer)
    else $error("buzzer while switch off");
  print_busy_a: assert property (
    $rose(ctrl_out.print_start) |-> print_go)
    else $error("busy missing after print start");
  print_wb_a: assert property (
    ctrl_out.print_start |=> ctrl_word_out_wr && !ctrl_word_out[BIT_PRINT])
    else $error("print bit not written back");
  busy_hold_a: assert property (
    ctrl_out.printer_busy && !local_in.print_done |=> ctrl_out.printer_busy)
    else $error("busy dropped early");
  busy_end_a: assert property (
    ctrl_out.printer_busy && local_in.print_done |=> !ctrl_out.printer_busy)
    else $error("busy stuck after done");
  no_restart_a: assert property (
    ctrl_out.printer_busy |-> !ctrl_out.print_start)
    else $error("print restarted while busy");
  win_close_a: assert property (
    ctrl_out.window_close |-> ctrl_out.window_inhibit)
    else $error("window close without inhibit");
  hist_pulse_a: assert property (
    ctrl_out.hist_init |=> !ctrl_out.hist_init)
    else $error("history pulse too long");
  hist_wb_a: assert property (
    local_in.hist_done |=> ctrl_word_out_wr
      && !ctrl_word_out[BIT_HIST_RESET])
    else $error("history bit not written back");
endmodule
bind tscw_top tscw_chk u_chk (.clk(clk), .rst_n(rst_n),
  .local_in(local_in), .ctrl_word_out(ctrl_word_out),
  .ctrl_word_out_wr(ctrl_word_out_wr), .ctrl_out(ctrl_out));
`default_nettype wire

// ==== verif/tscw_host.sv ====
// Host controller model that writes the shared control word.
`timescale 1ns/1ps
`default_nettype none
module tscw_host (
  input wire logic clk,
  input wire logic [15:0] ctrl_word_out,
  input wire logic ctrl_word_out_wr,
  output logic [15:0] ctrl_word_in,
  output logic ctrl_word_wr
);
  logic [15:0] mem; // Host copy of the shared word.
  initial begin
    ctrl_word_in = 16'hffff;
    ctrl_word_wr = 1'b0;
  end
  // The terminal's write-backs land in the shared word.
  always @(posedge clk) begin
    if (ctrl_word_out_wr) begin
      mem <= ctrl_word_out;
    end
  end
  // Each action is a fresh whole-word write.
  task automatic put(input logic [15:0] w);
    @(posedge clk);
    #1;
    ctrl_word_in = w;
    ctrl_word_wr = 1'b1;
    @(posedge clk);
    #1;
    ctrl_word_wr = 1'b0;
    ctrl_word_in = ~w; // Stale data is not left on the port.
  endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking testbench for the control word decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tscw_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sd = 1'b0; // Start-up complete.
  tscw_local_t loc; // Local terminal events.
  logic [15:0] w_in, w_out;
  logic w_wr, w_out_wr;
  tscw_ctrl_t co;
  int fail_count = 0;
  int checks_done = 0;
  int i;
  always #10 clk = ~clk;
  tscw_top dut (.clk(clk), .rst_n(rst_n), .ctrl_word_in(w_in),
    .ctrl_word_wr(w_wr), .startup_done(sd), .local_in(loc),
    .ctrl_word_out(w_out), .ctrl_word_out_wr(w_out_wr), .ctrl_out(co));
  tscw_host host (.clk(clk), .ctrl_word_out(w_out),
    .ctrl_word_out_wr(w_out_wr), .ctrl_word_in(w_in), .ctrl_word_wr(w_wr));
  // Compares one bit.
  task chk(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask
  // Lets the registered outputs settle.
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Writes a word and waits for its effect.
  task wr(input logic [15:0] w);
    host.put(w);
    settle();
  endtask
  // Waits a bounded time for a print start.
  task wait_print;
    for (i = 0; i < 8 && co.print_start !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  // Words before start-up do nothing.
  task t_start;
    loc.multi_drop_mode = 1'b1;
    wr(16'h4000);
    chk("prio_pre", 1'b0, co.priority_req);
    sd = 1'b1;
    settle();
    $display("start done");
  endtask
  // Priority follows bit 14 in multi-drop mode only.
  task t_prio;
    wr(16'h4000);
    chk("prio_on", 1'b1, co.priority_req);
    wr(16'h0000);
    chk("prio_off", 1'b0, co.priority_req);
    loc.multi_drop_mode = 1'b0;
    wr(16'h4000);
    chk("prio_mode", 1'b0, co.priority_req);
    wr(16'h0000);
    $display("prio done");
  endtask
  // Buzzer patterns, priority, stop switch and gate.
  task t_buz;
    loc.buzzer_enable_sw = 1'b1;
    wr(16'h3200);
    chk("buz_all", 1'b1, co.buzzer);
    loc.touch_buz_stop = 1'b1;
    @(posedge clk);
    #1;
    loc.touch_buz_stop = 1'b0;
    settle();
    chk("buz_stop", 1'b0, co.buzzer);
    wr(16'h0000);
    wr(16'h1000);
    chk("buz_short", 1'b1, co.buzzer);
    loc.buzzer_enable_sw = 1'b0;
    settle();
    chk("buz_gate", 1'b0, co.buzzer);
    wr(16'h0000);
    $display("buzzer done");
  endtask
  // History reset pulse and write-back.
  task t_hist;
    host.put(16'h0800);
    for (i = 0; i < 8 && co.hist_init !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("hist_init", 1'b1, co.hist_init);
    #1;
    loc.hist_done = 1'b1;
    @(posedge clk);
    #1;
    loc.hist_done = 1'b0;
    chk("hist_wb", 1'b1, w_out_wr);
    chk("hist_bit", 1'b0, w_out[BIT_HIST_RESET]);
    wr(16'h0000);
    $display("history done");
  endtask
  // Print start, busy, refusal while busy, completion.
  task t_print;
    chk("busy_idle", 1'b0, co.printer_busy);
    host.put(16'h0080);
    wait_print();
    chk("pr_start", 1'b1, co.print_start);
    @(posedge clk);
    #1;
    chk("pr_busy", 1'b1, co.printer_busy);
    chk("pr_wb", 1'b0, w_out[BIT_PRINT]);
    host.put(16'h0000);
    host.put(16'h0080);
    wait_print();
    chk("pr_again", 1'b0, co.print_start);
    loc.print_done = 1'b1;
    @(posedge clk);
    #1;
    loc.print_done = 1'b0;
    settle();
    chk("pr_end", 1'b0, co.printer_busy);
    wr(16'h0000);
    $display("print done");
  endtask
  // Inhibits, then blanking and restore.
  task t_misc;
    wr(16'h0060);
    chk("win_inh", 1'b1, co.window_inhibit);
    chk("ent_inh", 1'b1, co.entry_inhibit);
    wr(16'h8000);
    chk("ent_off", 1'b0, co.entry_inhibit);
    wr(16'h0000);
    chk("blank", 1'b0, co.display_on);
    chk("light", 1'b0, co.backlight_on);
    loc.touch_any = 1'b1;
    @(posedge clk);
    #1;
    loc.touch_any = 1'b0;
    settle();
    chk("restore", 1'b1, co.display_on);
    wr(16'h8000);
    chk("redisp", 1'b1, co.display_on);
    $display("misc done");
  endtask
  // Prints the counts and the verdict, then stops.
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end
  // Main sequence.
  initial begin
    loc = '0;
    loc.screen_buz_kind = TSCW_BUZ_OFF;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_start();
    t_prio();
    t_buz();
    t_hist();
    t_print();
    t_misc();
    tally_and_finish();
  end
endmodule
`default_nettype wire
